// ---- ats_engine.sv ----
// Time slot record engine for two serial audio ports.
// Assumes external FIFOs on the system clock and codecs on the link clock.
// Overview of operation
// [R1] Each slot drives every word select line to its bit in the slot record.
// [R2] Word select lines 0 and 4 ignore their record bit when set up as trigger inputs.
// [R3] Input select code 00 picks pin 0 for port two and pin 4 for port one, else pins 1 to 3.
// [R4] A set word-buffer load flag puts the captured byte into the next free word buffer byte.
// [R5] A set feedback load flag puts the captured byte into the next free feedback buffer byte.
// [R6] A set store flag writes the word buffer to the input FIFO.
// [R7] A set fetch flag moves the next output FIFO word into the output word buffer.
// [R8] Byte select codes 000 to 011 send output word buffer bytes 0 to 3 to the serializer.
// [R9] Byte select codes 100 to 111 send feedback buffer bytes 0 to 3 to the serializer.
// [R10] Output select code 00 drives pin 0 for port one and pin 4 for port two, else pins 1 to 3.
// [R11] When both ports pick the same output pin, port one drives it and port two is dropped.
// [R12] A pin that no port drives in a slot floats.
// [R13] A drive-low flag holds the previous slot's pin low for 7 bit clocks, then floats it.
// [R14] A record with the end of superframe bit makes the next slot use the first record.
// [R15] Each port walks its own list when independent; combined, one list of 32 records.
// [R16] One record is used per slot and the pointer steps by one unless it restarts.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module ats_engine (
   input  wire logic               clk_sys_i,
   input  wire logic               reset_i,
   input  wire logic [5:0]         reg_addr_i,
   input  wire logic [31:0]        reg_wdata_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   output logic      [31:0]        reg_rdata_o,
   output logic      [1:0][31:0]   in_word_o,
   output logic      [1:0]         in_push_o,
   input  wire logic [1:0][31:0]   out_word_i,
   input  wire logic [1:0]         out_empty_i,
   output logic      [1:0]         out_pop_o,
   input  wire logic               clk_link_i,
   input  wire logic [4:0]         sd_i,
   output logic      [4:0]         sd_o,
   output logic      [4:0]         sd_oe_o,
   output logic      [4:0]         ws_o,
   output logic      [4:0]         ws_oe_o
);
   // System clock state
   typedef struct packed {
      logic [31:0][31:0]            list;
      logic [ats_pkg::CTRL_W-1:0]   ctrl;
      logic                         primed;
      logic [1:0][ats_pkg::PW-1:0]  ptr;
      logic [1:0][31:0]             run;
      logic [1:0][31:0]             stg;
      logic [1:0][31:0]             wbuf;
      logic [1:0][31:0]             fbuf;
      logic [1:0][31:0]             obuf;
      logic [1:0][1:0]              wpos;
      logic [1:0][1:0]              fpos;
      logic [1:0][31:0]             in_word;
      logic [1:0]                   push;
      logic [1:0]                   pop;
      logic [31:0]                  rdata;
      logic [2:0]                   tgl_s;
   } ats_sys_s;

   // Link clock state
   typedef struct packed {
      logic [1:0]       rst_s;
      logic [1:0]       trg_s1;
      logic [1:0]       trg_s2;
      logic [4:0]       sd_s1;
      logic [4:0]       sd_s2;
      logic [2:0]       bcnt;
      logic [1:0][2:0]  cur_in;
      logic [1:0][2:0]  cur_out;
      logic [1:0][2:0]  prev_out;
      logic [1:0][2:0]  low_cnt;
      logic [1:0]       act;
      logic [4:0]       ws;
      logic [4:0]       ws_oe;
      logic [4:0]       sd;
      logic [4:0]       sd_oe;
   } ats_lnk_s;

   ats_sys_s q;
   ats_sys_s d;
   ats_lnk_s ql;
   ats_lnk_s dl;

   // Staged slot bundle, held steady for a whole slot before the link takes it
   logic [1:0][2:0]         bnd_in;
   logic [1:0][2:0]         bnd_out;
   logic [1:0][7:0]         bnd_byte;
   logic [1:0]              bnd_low;
   logic [1:0]              bnd_act;
   logic [4:0]              bnd_ws;
   logic [1:0][7:0]         cap_b;
   logic [1:0]              tx_b;
   logic                    slot_end;
   logic                    evt;
   logic                    stg_fire;
   logic [ats_pkg::PW-1:0]  base;
   logic [ats_pkg::PW-1:0]  idx;
   logic [ats_pkg::PW-1:0]  lim;
   logic [31:0]             rec;
   logic [31:0]             r;

   ats_lane_if lane_if [ats_pkg::NPORT] ();

   assign slot_end = (ql.bcnt == ats_pkg::SLOT_LAST);
   // Both lanes share one bit clock, so lane 0's toggle marks every slot
   assign evt      = q.tgl_s[2] ^ q.tgl_s[1];
   assign stg_fire = q.ctrl[ats_pkg::C_EN] && (!q.primed || evt);

   // Per-port bundle decode and lanes
   for (genvar g = 0; g < ats_pkg::NPORT; g++) begin : g_port
      localparam int SH = g * ats_pkg::PSTRIDE;
      logic [1:0] dis;
      logic [1:0] dod;
      logic [2:0] bsel;
      assign dis  = q.stg[g][ats_pkg::F_DIS-SH +: 2];
      assign dod  = q.stg[g][ats_pkg::F_DOD-SH +: 2];
      assign bsel = q.stg[g][ats_pkg::F_BSEL-SH +: 3];
      // Code 00 maps to different pins per port, the others are shared
      assign bnd_in[g]  = (dis != 2'h0) ? {1'b0, dis} :
                          ((g == 0) ? ats_pkg::PIN_HI : ats_pkg::PIN_LO);  // [R3]
      assign bnd_out[g] = (dod != 2'h0) ? {1'b0, dod} :
                          ((g == 0) ? ats_pkg::PIN_LO : ats_pkg::PIN_HI);  // [R10]
      assign bnd_byte[g] = bsel[2] ? q.fbuf[g][{bsel[1:0], 3'h0} +: 8]   // [R9]
                                   : q.obuf[g][{bsel[1:0], 3'h0} +: 8];  // [R8]
      assign bnd_low[g] = q.stg[g][ats_pkg::F_LOW-SH];
      assign bnd_act[g] = q.primed;

      assign lane_if[g].slot_end = slot_end;
      assign lane_if[g].tx_load  = bnd_byte[g];
      assign lane_if[g].rx_bit   = ql.sd_s2[ql.cur_in[g]];
      assign tx_b[g]             = lane_if[g].tx_bit;
      assign cap_b[g]            = lane_if[g].cap_byte;

      ats_lane u_lane (
         .clk_link_i (clk_link_i),
         .lrst_i     (ql.rst_s[1]),
         .lk         (lane_if[g])
      );
   end

   // Word select pattern comes from port one's record
   for (genvar n = 0; n < ats_pkg::NWS; n++) begin : g_ws
      assign bnd_ws[n] = q.stg[0][ats_pkg::F_WS0-n];
   end

   // System side: register port, list walk and buffer moves
   always_comb begin
      d       = q;
      d.tgl_s = {q.tgl_s[1:0], lane_if[0].cap_tgl};
      d.push  = '0;
      d.pop   = '0;
      d.rdata = '0;
      base    = '0;
      idx     = '0;
      lim     = '0;
      rec     = '0;
      r       = '0;
      if (reg_wr_i) begin
         if (!reg_addr_i[ats_pkg::A_LIST_BIT]) begin
            d.list[reg_addr_i[ats_pkg::PW-1:0]] = reg_wdata_i;
         end else if (reg_addr_i == ats_pkg::A_CTRL) begin
            d.ctrl = reg_wdata_i[ats_pkg::CTRL_W-1:0];
         end
      end
      // The list is write only and reads back as zero
      if (reg_rd_i) begin
         if (reg_addr_i == ats_pkg::A_CTRL) begin
            d.rdata = 32'(q.ctrl);
         end else if (reg_addr_i == ats_pkg::A_STAT) begin
            d.rdata = 32'({q.primed, q.fpos, q.wpos, q.ptr});
         end
      end
      if (!q.ctrl[ats_pkg::C_EN]) begin
         d.primed = 1'b0;
         d.ptr    = '0;
         d.run    = '0;
         d.stg    = '0;
      end else if (stg_fire) begin
         d.primed = 1'b1;
         // Settle the slot that just ended, using its own record
         if (q.primed) begin
            for (int p = 0; p < ats_pkg::NPORT; p++) begin
               r = q.run[p];
               if (r[ats_pkg::F_SDW - p*ats_pkg::PSTRIDE]) begin
                  d.wbuf[p][{q.wpos[p], 3'h0} +: 8] = cap_b[p];  // [R4]
                  d.wpos[p] = q.wpos[p] + 2'h1;
               end
               if (r[ats_pkg::F_SIB - p*ats_pkg::PSTRIDE]) begin
                  d.fbuf[p][{q.fpos[p], 3'h0} +: 8] = cap_b[p];  // [R5]
                  d.fpos[p] = q.fpos[p] + 2'h1;
               end
               // Store after load, so this slot's byte goes out with the word
               if (r[ats_pkg::F_SF - p*ats_pkg::PSTRIDE]) begin
                  d.in_word[p] = d.wbuf[p];                       // [R6]
                  d.push[p]    = 1'b1;
               end
               // An empty FIFO leaves the old word in place
               if (r[ats_pkg::F_LF - p*ats_pkg::PSTRIDE] && !out_empty_i[p]) begin
                  d.obuf[p] = out_word_i[p];                      // [R7]
                  d.pop[p]  = 1'b1;
               end
            end
            d.run = q.stg;
         end
         // Stage the next record; combined mode shares pointer 0
         for (int p = 0; p < ats_pkg::NPORT; p++) begin
            base = q.ctrl[ats_pkg::C_COMB] ? q.ptr[0] : q.ptr[p];
            idx  = q.ctrl[ats_pkg::C_COMB] ? base :
                   base + ats_pkg::PW'(p * ats_pkg::HALF_DEPTH);  // [R15]
            lim  = q.ctrl[ats_pkg::C_COMB] ? ats_pkg::PW'(ats_pkg::LIST_DEPTH - 1)
                                           : ats_pkg::PW'(ats_pkg::HALF_DEPTH - 1);
            rec  = q.list[idx];
            d.stg[p] = rec;
            if (rec[ats_pkg::F_EOS] || base >= lim) begin
               d.ptr[p] = '0;                                     // [R14]
            end else begin
               d.ptr[p] = base + ats_pkg::PW'(1);                 // [R16]
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Link side: slot timing, pin routing and word select levels
   always_comb begin
      dl        = ql;
      dl.rst_s  = {ql.rst_s[0], reset_i};
      dl.trg_s1 = {q.ctrl[ats_pkg::C_TRIG4], q.ctrl[ats_pkg::C_TRIG0]};
      dl.trg_s2 = ql.trg_s1;
      dl.sd_s1  = sd_i;
      dl.sd_s2  = ql.sd_s1;
      dl.bcnt   = ql.bcnt + 3'h1;
      // Trigger lines become inputs, so they are never driven
      dl.ws_oe  = ~{ql.trg_s2[1], 3'h0, ql.trg_s2[0]};            // [R2]
      for (int p = 0; p < ats_pkg::NPORT; p++) begin
         if (ql.low_cnt[p] != 3'h0) begin
            dl.low_cnt[p] = ql.low_cnt[p] - 3'h1;
         end
      end
      // A line that turns into a trigger input drops its level at once, not at the next slot
      dl.ws     = ql.ws & dl.ws_oe;                               // [R2]
      if (slot_end) begin
         for (int p = 0; p < ats_pkg::NPORT; p++) begin
            // Remember the pin just used before the new record takes over
            if (bnd_low[p] && ql.act[p]) begin
               dl.prev_out[p] = ql.cur_out[p];
               dl.low_cnt[p]  = ats_pkg::LOW_BITS;                // [R13]
            end
            dl.cur_in[p]  = bnd_in[p];
            dl.cur_out[p] = bnd_out[p];
            dl.act[p]     = bnd_act[p];
         end
         dl.ws = bnd_ws & dl.ws_oe;                               // [R1] [R2]
      end
      // Pins: port one wins, then port two, then a pending drive-low
      for (int k = 0; k < ats_pkg::NPIN; k++) begin
         dl.sd[k]    = 1'b0;
         dl.sd_oe[k] = 1'b0;                                      // [R12]
         if (ql.act[0] && ql.cur_out[0] == 3'(k)) begin
            dl.sd[k]    = tx_b[0];                                // [R11]
            dl.sd_oe[k] = 1'b1;
         end else if (ql.act[1] && ql.cur_out[1] == 3'(k)) begin
            dl.sd[k]    = tx_b[1];
            dl.sd_oe[k] = 1'b1;
         end else if ((ql.low_cnt[0] != 3'h0 && ql.prev_out[0] == 3'(k)) ||
                      (ql.low_cnt[1] != 3'h0 && ql.prev_out[1] == 3'(k))) begin
            dl.sd_oe[k] = 1'b1;                                   // [R13]
         end
      end
      // Synchronous reset once it has crossed into this domain
      if (ql.rst_s[1]) begin
         dl.bcnt     = '0;
         dl.cur_in   = '0;
         dl.cur_out  = '0;
         dl.prev_out = '0;
         dl.low_cnt  = '0;
         dl.act      = '0;
         dl.ws       = '0;
         dl.ws_oe    = '0;
         dl.sd       = '0;
         dl.sd_oe    = '0;
      end
   end

   always_ff @(posedge clk_link_i) begin
      ql <= dl;
   end

   // Outputs straight from flops
   assign reg_rdata_o = q.rdata;
   assign in_word_o   = q.in_word;
   assign in_push_o   = q.push;
   assign out_pop_o   = q.pop;
   assign sd_o        = ql.sd;
   assign sd_oe_o     = ql.sd_oe;
   assign ws_o        = ql.ws;
   assign ws_oe_o     = ql.ws_oe;

   // Checks on the system side
   a_eos_restart: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      stg_fire ##1 q.stg[0][ats_pkg::F_EOS] |-> q.ptr[0] == '0)  // [R14]
      else $error("pointer did not restart after end of superframe");

   a_ptr_step: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      stg_fire ##1 (!q.stg[0][ats_pkg::F_EOS] && q.ptr[0] != '0)
      |-> q.ptr[0] == $past(q.ptr[0]) + 5'h01)  // [R16]
      else $error("pointer did not step by one record");

   a_word_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (stg_fire && q.primed && q.run[0][ats_pkg::F_SDW])
      |=> q.wpos[0] == $past(q.wpos[0]) + 2'h1)  // [R4]
      else $error("word buffer position did not advance");

   a_store_push: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (stg_fire && q.primed && q.run[0][ats_pkg::F_SF])
      |=> in_push_o[0] && in_word_o[0] == q.wbuf[0] ##1 !in_push_o[0])  // [R6]
      else $error("store flag did not push one word");

   a_fetch_pop: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (stg_fire && q.primed && q.run[0][ats_pkg::F_LF] && !out_empty_i[0])
      |=> out_pop_o[0] && q.obuf[0] == $past(out_word_i[0]))  // [R7]
      else $error("fetch flag did not load the output word");

   // Checks on the link side
   sequence s_low_load;
      slot_end && bnd_low[0] && ql.act[0];
   endsequence

   sequence s_low_hold;
      (ql.low_cnt[0] != 3'h0)[*7] ##1 (ql.low_cnt[0] == 3'h0);
   endsequence

   a_low_hold: assert property (@(posedge clk_link_i) disable iff (ql.rst_s[1])
      s_low_load |=> s_low_hold)  // [R13]
      else $error("drive low did not last seven bit clocks");

   a_ws_level: assert property (@(posedge clk_link_i) disable iff (ql.rst_s[1])
      slot_end |=> ws_o[2] == $past(bnd_ws[2]))  // [R1]
      else $error("word select level differs from record");

   a_ws_trigger: assert property (@(posedge clk_link_i) disable iff (ql.rst_s[1])
      (ql.trg_s2[0] && $stable(ql.trg_s2[0])) |=> !ws_o[0] && !ws_oe_o[0])  // [R2]
      else $error("trigger line driven from record");

   a_pin_prio: assert property (@(posedge clk_link_i) disable iff (ql.rst_s[1])
      (ql.act[0] && ql.act[1] && ql.cur_out[0] == ql.cur_out[1])
      |=> sd_oe_o[$past(ql.cur_out[0])] && sd_o[$past(ql.cur_out[0])] == $past(tx_b[0]))  // [R11]
      else $error("port one did not win a shared pin");

   a_pin_float: assert property (@(posedge clk_link_i) disable iff (ql.rst_s[1])
      (ql.act == 2'h0 && ql.low_cnt == '0) |=> sd_oe_o == 5'h00)  // [R12]
      else $error("idle pin was driven");
endmodule // ats_engine

// ---- ats_pkg.sv ----
// Constants shared by the time slot record engine and its bit lanes.
// Assumes both audio ports share one bit clock and eight bits per slot.
package ats_pkg;
   // Sizes
   localparam int NPORT      = 2;       // Audio port one, audio port two
   localparam int LIST_DEPTH = 32;      // Combined slot record list
   localparam int HALF_DEPTH = 16;      // Per-port list when independent
   localparam int PW         = 5;       // List pointer width
   localparam int NPIN       = 5;       // Serial data pins 0..4
   localparam int NWS        = 5;       // Word select lines 0..4
   localparam int SLOT_BITS  = 8;

   // Slot record fields; port two fields sit PSTRIDE bits below port one
   localparam int PSTRIDE = 13;
   localparam int F_WS0   = 31;         // Word select line n at F_WS0-n
   localparam int F_DIS   = 24;
   localparam int F_SDW   = 23;
   localparam int F_SIB   = 22;
   localparam int F_SF    = 21;
   localparam int F_LF    = 20;
   localparam int F_BSEL  = 17;
   localparam int F_DOD   = 15;
   localparam int F_LOW   = 14;
   localparam int F_EOS   = 0;

   // Register port map (word addresses)
   localparam int         A_LIST_BIT = 5;     // Low half is the write-only list
   localparam logic [5:0] A_CTRL     = 6'h20;
   localparam logic [5:0] A_STAT     = 6'h21;
   localparam int         CTRL_W     = 4;
   localparam int         C_EN       = 0;
   localparam int         C_COMB     = 1;
   localparam int         C_TRIG0    = 2;
   localparam int         C_TRIG4    = 3;

   // Link timing and pin codes
   localparam logic [2:0] SLOT_LAST = 3'h7;   // Last bit of a slot
   localparam logic [2:0] LOW_BITS  = 3'h7;   // Drive-low length in bit clocks
   localparam logic [2:0] PIN_LO    = 3'h0;
   localparam logic [2:0] PIN_HI    = 3'h4;
endpackage

// ---- ats_lane_if.sv ----
// Signals between the engine's link logic and one per-port bit lane.
// Assumes everything here lives in the link clock domain.
`timescale 1ns/1ps
interface ats_lane_if;
   logic       slot_end;   // Last bit clock of the slot
   logic [7:0] tx_load;    // Byte to serialize in the next slot
   logic       rx_bit;     // Captured serial bit, already synchronised
   logic       tx_bit;     // Current serial output bit
   logic [7:0] cap_byte;   // Byte captured in the last slot
   logic       cap_tgl;    // Toggles once per slot

   modport ctl  (output slot_end, tx_load, rx_bit, input tx_bit, cap_byte, cap_tgl);
   modport lane (input slot_end, tx_load, rx_bit, output tx_bit, cap_byte, cap_tgl);
endinterface // ats_lane_if

// ---- ats_lane.sv ----
// One bit lane: serial capture and serializer for one audio port.
// Assumes a synchronous reset already aligned to the link clock.
`timescale 1ns/1ps
module ats_lane (
   input  wire logic clk_link_i,
   input  wire logic lrst_i,
   ats_lane_if.lane  lk
);
   typedef struct packed {
      logic [7:0] rx;
      logic [7:0] tx;
      logic [7:0] cap;
      logic       tgl;
   } ats_lane_s;

   ats_lane_s q;
   ats_lane_s d;

   // Shift both ways every bit; slot end hands over whole bytes
   always_comb begin
      d    = q;
      d.rx = {q.rx[6:0], lk.rx_bit};
      d.tx = {q.tx[6:0], 1'b0};
      if (lk.slot_end) begin
         d.cap = {q.rx[6:0], lk.rx_bit};
         d.tgl = ~q.tgl;         // Event for the system side
         d.tx  = lk.tx_load;     // MSB goes out first
      end
      if (lrst_i) begin
         d = '0;
      end
   end

   always_ff @(posedge clk_link_i) begin
      q <= d;
   end

   // Capture byte is held a whole slot so the other domain can read it
   assign lk.cap_byte = q.cap;
   assign lk.cap_tgl  = q.tgl;
   assign lk.tx_bit   = q.tx[7];
endmodule // ats_lane

// ---- ats_codec_model.sv ----
// Codec model on the serial data pins of the time slot record engine.
// Assumes it is clocked by the free running bit clock the bench makes.
`timescale 1ns/1ps
module ats_codec_model (
   input  wire logic       clk_link_i,
   input  wire logic [4:0] drv_lvl_i,
   input  wire logic [4:0] drv_en_i,
   output logic      [4:0] pin_lvl_o
);
   logic       tog_q;
   logic [4:0] codec_lvl;

   // Pins 0 and 4 have no pull: they toggle when nobody drives them, so no stale level looks valid
   initial tog_q = 1'b0;
   always_ff @(posedge clk_link_i) begin
      tog_q <= ~tog_q;
   end

   // Pins 1 to 3 carry constant words, so the captured byte does not depend on slot alignment
   assign codec_lvl = {tog_q, 1'b1, 1'b0, 1'b1, ~tog_q};

   // Wire level: the engine's driver wins where it is enabled
   always_comb begin
      for (int k = 0; k < 5; k++) begin
         pin_lvl_o[k] = drv_en_i[k] ? drv_lvl_i[k] : codec_lvl[k];
      end
   end
endmodule // ats_codec_model

// ---- tb_top.sv ----
// Self-checking bench: register tasks, a slot monitor on the bit clock and a table of list records.
// Assumes the codec model on the pins and output FIFOs that hold one constant word each.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin bad_count++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
   typedef struct packed {logic [31:0] rec; logic lvl;} ats_row_s;
   logic              clk_sys_i, clk_link_i, reset_i, reg_wr_i, reg_rd_i;
   logic [5:0]        reg_addr_i;
   logic [31:0]       reg_wdata_i, reg_rdata_o, d;
   logic [1:0][31:0]  in_word_o, out_word_i;
   logic [1:0]        in_push_o, out_empty_i, out_pop_o;
   logic [4:0]        sd_i, sd_o, sd_oe_o, ws_o, ws_oe_o, last_ws;
   int                bad_count, checked, cycles, pushes, pops0, pops1, mid, phase;
   // Port one records 0..7: ws_o shows the record index, pairs of slots share an input pin
   localparam ats_row_s ROWS [8] = '{'{32'h11100000, 1'b0}, '{32'h91C20000, 1'b1}, '{32'h52040000, 1'b0},
      '{32'hD2C60000, 1'b1}, '{32'h33080000, 1'b1}, '{32'hB3CA0000, 1'b0}, '{32'h700C0000, 1'b1},
      '{32'hF0EE0001, 1'b1}};

   ats_engine dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .in_word_o(in_word_o), .in_push_o(in_push_o), .out_word_i(out_word_i), .out_empty_i(out_empty_i),
      .out_pop_o(out_pop_o), .clk_link_i(clk_link_i), .sd_i(sd_i), .sd_o(sd_o), .sd_oe_o(sd_oe_o),
      .ws_o(ws_o), .ws_oe_o(ws_oe_o));
   ats_codec_model codec_u (.clk_link_i(clk_link_i), .drv_lvl_i(sd_o), .drv_en_i(sd_oe_o), .pin_lvl_o(sd_i));

   // Clocks: unrelated phases
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      clk_link_i = 1'b0;
      #3.1;
      forever #62.5 clk_link_i = ~clk_link_i;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One-cycle write strobe; the gap before the next call keeps strobes single assignments per step
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the taking edge
   task automatic rd(input logic [5:0] a, output logic [31:0] v);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      @(negedge clk_sys_i);
      v = reg_rdata_o;
   endtask

   // System side: input FIFO pushes, output FIFO pops, timeout
   always @(posedge clk_sys_i) begin
      cycles++;
      if (in_push_o[0] === 1'b1) begin
         pushes++;
         if (phase == 1) `CHK("input word", 32'hFFFF00FF, in_word_o[0])
      end
      if (out_pop_o[0] === 1'b1) pops0++;
      if (out_pop_o[1] === 1'b1) pops1++;
      if (cycles == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // Link side: slot order at each ws change, pin state in mid-slot
   always @(negedge clk_link_i) begin
      if (ws_o !== last_ws) begin
         if (phase != 0) begin
            `CHK("slot step", last_ws[2:0] + 3'h1, ws_o[2:0])
            `CHK("ws pattern", 2'b01, ws_o[4:3])
         end
         last_ws = ws_o;
         mid = 0;
      end else begin
         mid++;
      end
      if (mid == 4 && phase == 1) begin
         `CHK("pin enables", 5'h11, sd_oe_o)
         `CHK("pin0 level", ROWS[ws_o[2:0]].lvl, sd_o[0])
         `CHK("ws enables", 5'h1F, ws_oe_o)
      end
      if (mid == 4 && phase == 2) begin
         `CHK("pin enables", (ws_o[2:0] == 3'h3) ? 5'h02 : 5'h03, sd_oe_o)
         `CHK("pin1 level", ws_o[2:0] == 3'h3, sd_o[1])
      end
      // Slot 4 holds slot 3's pin 1 low while both ports keep their own pins
      if (mid == 4 && phase == 3) begin
         `CHK("pin enables", (ws_o[2:0] == 3'h3) ? 5'h12 : ((ws_o[2:0] == 3'h4) ? 5'h13 : 5'h11), sd_oe_o)
         `CHK("low level", 1'b0, sd_o[1] & (ws_o[2:0] == 3'h4))
      end
   end

   // Main sequence
   initial begin
      reset_i = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 6'h00;
      reg_wdata_i = 32'h0;
      out_word_i[0] = 32'hFF00FF00;
      out_word_i[1] = 32'h000000FF;
      out_empty_i = 2'b00;
      last_ws = 5'h00;
      phase = 0;
      // Held long enough to reach the link domain through its synchronisers
      repeat (48) @(posedge clk_sys_i);
      `CHK("outputs in reset", 36'h0, {reg_rdata_o, in_push_o, out_pop_o})
      `CHK("input word in reset", 64'h0, in_word_o)
      reset_i <= 1'b0;
      for (int k = 0; k < 8; k++) wr(6'(k), ROWS[k].rec);
      wr(6'h10, 32'h00000081);
      rd(6'h01, d);
      `CHK("list read", 32'h0, d)
      rd(6'h30, d);
      `CHK("unmapped read", 32'h0, d)
      wr(ats_pkg::A_CTRL, 32'h1);
      rd(ats_pkg::A_CTRL, d);
      `CHK("control read", 32'h1, d)
      rd(ats_pkg::A_STAT, d);
      `CHK("primed", 1'b1, d[18])
      repeat (2400) @(posedge clk_sys_i);
      pushes = 0;
      pops0 = 0;
      pops1 = 0;
      phase = 1;
      repeat (2400) @(posedge clk_sys_i);
      `CHK("push count", 1'b1, pushes >= 2)
      `CHK("port two pops", 1'b1, pops1 >= 2)
      `CHK("pop count", 1'b1, pops0 >= 2)
      // Collision: port one moves to pin 1 in slot 3, port two sits on pin 1 throughout
      phase = 0;
      out_empty_i <= 2'b01;
      wr(6'h03, 32'hD2C68000);
      wr(6'h10, 32'h00000095);
      repeat (1600) @(posedge clk_sys_i);
      pops0 = 0;
      phase = 2;
      repeat (1600) @(posedge clk_sys_i);
      `CHK("pop while empty", 0, pops0)
      phase = 0;
      // Drive-low: port two back on pin 4, record 4 lowers the pin port one used in slot 3
      wr(6'h04, 32'h33084000);
      wr(6'h10, 32'h00000081);
      repeat (1600) @(posedge clk_sys_i);
      phase = 3;
      repeat (1600) @(posedge clk_sys_i);
      phase = 0;
      wr(ats_pkg::A_CTRL, 32'h5);
      repeat (400) @(posedge clk_sys_i);
      `CHK("trigger enables", 5'h1E, ws_oe_o)
      report_and_stop();
   end
endmodule // tb_top
